/* rtl/baud_timer.sv */
`timescale 1ns/1ps
module baud_timer (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic       force_reload,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic [7:0] reload_byte,
  output logic [7:0]      count_q,
  output logic            ovf_q
);

  // 8-bit up counter reloading from reload_byte on overflow
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= uart_pkg::BYTE_RESET;
      ovf_q   <= 1'b0;
    end else begin
      ovf_q <= 1'b0;
      if (force_reload) begin
        count_q <= reload_byte;
      end else if (load) begin
        count_q <= load_val;
      end else if (run && tick) begin
        if (count_q == 8'hff) begin
          count_q <= reload_byte;
          ovf_q   <= 1'b1;
        end else begin
          count_q <= count_q + 8'h01;
        end
      end
    end
  end

endmodule : baud_timer

/* rtl/timer_prescaler.sv */
`timescale 1ns/1ps
module timer_prescaler (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] sel,
  input  wire logic       ext_osc,
  input  wire logic       timer_ext_input,
  output logic            tick_q
);

  logic [5:0] pre_q;
  logic [2:0] osc_cnt_q;
  logic       osc_prev_q;
  logic       pin_prev_q;
  logic       osc_rise;
  logic       tick_d;

  assign osc_rise = ext_osc && !osc_prev_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q      <= 6'h00;
      osc_cnt_q  <= 3'h0;
      osc_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pre_q      <= (pre_q == uart_pkg::PRE_WRAP) ? 6'h00 : pre_q + 6'h01;
      osc_prev_q <= ext_osc;
      pin_prev_q <= timer_ext_input;
      if (osc_rise) begin
        osc_cnt_q <= osc_cnt_q + 3'h1;
      end
    end
  end

  // one common mod-48 counter serves all three system clock ratios
  always_comb begin
    case (sel)
      uart_pkg::SEL_DIV4:  tick_d = (pre_q[1:0] == 2'h3);
      uart_pkg::SEL_DIV12: tick_d = (pre_q == 6'h0b) || (pre_q == 6'h17) || (pre_q == 6'h23) || (pre_q == 6'h2f);
      uart_pkg::SEL_DIV48: tick_d = (pre_q == uart_pkg::PRE_WRAP);
      uart_pkg::SEL_OSC8:  tick_d = osc_rise && (osc_cnt_q == uart_pkg::OSC_WRAP);
      uart_pkg::SEL_PIN:   tick_d = timer_ext_input && !pin_prev_q;
      default:             tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

endmodule : timer_prescaler

/* rtl/uart_buffer_baud_gen.sv */
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module uart_buffer_baud_gen (
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire uart_pkg::axi_req_t axi_req,
  output uart_pkg::axi_rsp_t      axi_rsp,
  input  wire logic               rx_pin,
  input  wire logic               ext_osc,
  input  wire logic               timer_ext_input,
  output logic                    tx_pin_q,
  output logic                    irq_q
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  function automatic uart_pkg::reg_sel_t decode(input logic [7:0] addr);
    case (addr)
      uart_pkg::OFS_CTRL:   decode = uart_pkg::SEL_CTRL;
      uart_pkg::OFS_DATA:   decode = uart_pkg::SEL_DATA;
      uart_pkg::OFS_TIMER:  decode = uart_pkg::SEL_TIMER;
      uart_pkg::OFS_COUNT:  decode = uart_pkg::SEL_COUNT;
      uart_pkg::OFS_RELOAD: decode = uart_pkg::SEL_RELOAD;
      default:              decode = uart_pkg::SEL_NONE;
    endcase
  endfunction : decode

  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_held_q, w_held_q, wstrb0_q;
  logic [7:0]  awaddr_q, wbyte_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        wr_fire, ar_fire;
  uart_pkg::reg_sel_t wsel, rsel;

  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign ar_fire = axi_req.arvalid && arready_q;
  assign wsel    = decode(awaddr_q);
  assign rsel    = decode(axi_req.araddr);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wbyte_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= uart_pkg::RESP_OKAY;
    end else begin
      if (axi_req.awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_held_q <= 1'b1;
        awaddr_q  <= axi_req.awaddr;
      end
      if (axi_req.wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_held_q <= 1'b1;
        wbyte_q  <= axi_req.wdata[7:0];
        wstrb0_q <= axi_req.wstrb[0];
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wsel == uart_pkg::SEL_NONE) ? uart_pkg::RESP_SLVERR : uart_pkg::RESP_OKAY;
      end
      if (bvalid_q && axi_req.bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // only byte lane 0 carries register data; other lanes are ignored
  logic wr_ctrl, wr_data, wr_timer, wr_count, wr_reload;
  assign wr_ctrl   = wr_fire && wstrb0_q && (wsel == uart_pkg::SEL_CTRL);
  assign wr_data   = wr_fire && wstrb0_q && (wsel == uart_pkg::SEL_DATA);
  assign wr_timer  = wr_fire && wstrb0_q && (wsel == uart_pkg::SEL_TIMER);
  assign wr_count  = wr_fire && wstrb0_q && (wsel == uart_pkg::SEL_COUNT);
  assign wr_reload = wr_fire && wstrb0_q && (wsel == uart_pkg::SEL_RELOAD);

  // ----------------------------------------
  // software state
  // ----------------------------------------
  uart_pkg::ctrl_t ctrl_q, wctrl;
  logic       tmr_run_q, int_en_q;
  logic [2:0] clk_sel_q;
  logic [7:0] reload_q, rx_buf_q;
  logic [7:0] tx_count, rx_count;
  logic       tx_done_set, rx_load;
  logic       rx_bit9_val;

  assign wctrl = uart_pkg::ctrl_t'(wbyte_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= uart_pkg::ctrl_t'(uart_pkg::CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_q.mode9    <= wctrl.mode9;
        ctrl_q.check_en <= wctrl.check_en;
        ctrl_q.rx_en    <= wctrl.rx_en;
        ctrl_q.tx_bit9  <= wctrl.tx_bit9;
        ctrl_q.rx_bit9  <= wctrl.rx_bit9;
      end
      if (rx_load) begin
        ctrl_q.rx_bit9 <= rx_bit9_val;
      end
      // hardware set wins over a software clear in the same cycle
      ctrl_q.tx_done_flag <= tx_done_set || (wr_ctrl ? wctrl.tx_done_flag : ctrl_q.tx_done_flag);
      ctrl_q.rx_done_flag <= rx_load || (wr_ctrl ? wctrl.rx_done_flag : ctrl_q.rx_done_flag);
      ctrl_q.fixed_one    <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_run_q <= 1'b0;
      int_en_q  <= 1'b0;
      clk_sel_q <= uart_pkg::SEL_DIV12;
      reload_q  <= uart_pkg::BYTE_RESET;
    end else begin
      if (wr_timer) begin
        tmr_run_q <= wbyte_q[uart_pkg::TMR_RUN_BIT];
        int_en_q  <= wbyte_q[uart_pkg::TMR_IE_BIT];
        clk_sel_q <= wbyte_q[uart_pkg::TMR_SEL_LSB +: 3];
      end
      if (wr_reload) begin
        reload_q <= wbyte_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= int_en_q && (ctrl_q.tx_done_flag || ctrl_q.rx_done_flag);
    end
  end

  // read data path; the transmit shifter has no read path at all
  logic [7:0] rd_byte;
  always_comb begin
    case (rsel)
      uart_pkg::SEL_CTRL:   rd_byte = ctrl_q;
      uart_pkg::SEL_DATA:   rd_byte = rx_buf_q;
      uart_pkg::SEL_TIMER:  rd_byte = {int_en_q, 3'h0, clk_sel_q, tmr_run_q};
      uart_pkg::SEL_COUNT:  rd_byte = tx_count;
      uart_pkg::SEL_RELOAD: rd_byte = reload_q;
      default:              rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= uart_pkg::RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h00_0000, rd_byte};
        rresp_q   <= (rsel == uart_pkg::SEL_NONE) ? uart_pkg::RESP_SLVERR : uart_pkg::RESP_OKAY;
      end else if (rvalid_q && axi_req.rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                     arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

  // ----------------------------------------
  // baud generation
  // ----------------------------------------
  logic tmr_tick, tx_ovf, rx_ovf, start_det;
  logic tx_div_q, rx_div_q;
  logic tx_bit_tick, rx_samp;

  timer_prescaler u_pre (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .sel             (clk_sel_q),
    .ext_osc         (ext_osc),
    .timer_ext_input (timer_ext_input),
    .tick_q          (tmr_tick)
  );

  // visible counter drives the transmitter
  baud_timer u_tx_tmr (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .tick         (tmr_tick),
    .run          (tmr_run_q),
    .force_reload (1'b0),
    .load         (wr_count),
    .load_val     (wbyte_q),
    .reload_byte  (reload_q),
    .count_q      (tx_count),
    .ovf_q        (tx_ovf)
  );

  // hidden copy drives the receiver and restarts on each start edge
  baud_timer u_rx_tmr (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .tick         (tmr_tick),
    .run          (tmr_run_q),
    .force_reload (start_det),
    .load         (1'b0),
    .load_val     (8'h00),
    .reload_byte  (reload_q),
    .count_q      (rx_count),
    .ovf_q        (rx_ovf)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_div_q <= 1'b0;
      rx_div_q <= 1'b0;
    end else begin
      if (tx_ovf) begin
        tx_div_q <= !tx_div_q;
      end
      if (start_det) begin
        rx_div_q <= 1'b0;
      end else if (rx_ovf) begin
        rx_div_q <= !rx_div_q;
      end
    end
  end

  assign tx_bit_tick = tx_ovf && tx_div_q;
  // first overflow after the forced reload falls half a bit in: mid-bit sampling
  assign rx_samp     = rx_ovf && !rx_div_q;

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [10:0] tx_shift_q;
  logic [3:0]  tx_cnt_q;

  // a write while a frame is going out restarts the frame with the new byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_q <= 11'h7ff;
      tx_cnt_q   <= 4'h0;
      tx_pin_q   <= 1'b1;
    end else if (wr_data) begin
      tx_shift_q <= {1'b1, ctrl_q.mode9 ? ctrl_q.tx_bit9 : 1'b1, wbyte_q, 1'b0};
      tx_cnt_q   <= ctrl_q.mode9 ? uart_pkg::FRAME9_BITS : uart_pkg::FRAME8_BITS;
    end else if (tx_bit_tick && (tx_cnt_q != 4'h0)) begin
      tx_pin_q   <= tx_shift_q[0];
      tx_shift_q <= {1'b1, tx_shift_q[10:1]};
      tx_cnt_q   <= tx_cnt_q - 4'h1;
    end
  end

  assign tx_done_set = tx_bit_tick && (tx_cnt_q == 4'h1) && !wr_data;

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic [2:0] rx_sync_q;
  logic       rx_line;
  uart_pkg::rx_state_t rx_st_q;
  logic [8:0] rx_shift_q;
  logic [3:0] rx_cnt_q;
  logic       rx_ok;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_q <= 3'h7;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_pin};
    end
  end

  assign rx_line   = rx_sync_q[1];
  assign start_det = (rx_st_q == uart_pkg::RX_IDLE) && ctrl_q.rx_en && rx_sync_q[2] && !rx_line;
  assign rx_bit9_val = ctrl_q.mode9 ? rx_shift_q[8] : rx_line;
  // the receive buffer is separate from the shifter, so a new frame may start at once
  assign rx_ok  = !ctrl_q.rx_done_flag && (!ctrl_q.check_en || rx_bit9_val);
  assign rx_load = rx_samp && (rx_st_q == uart_pkg::RX_STOP) && rx_ok;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q    <= uart_pkg::RX_IDLE;
      rx_shift_q <= 9'h000;
      rx_cnt_q   <= 4'h0;
    end else begin
      case (rx_st_q)
        uart_pkg::RX_IDLE: begin
          if (start_det) begin
            rx_st_q  <= uart_pkg::RX_START;
            rx_cnt_q <= 4'h0;
          end
        end
        uart_pkg::RX_START: begin
          if (rx_samp) begin
            rx_st_q <= rx_line ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          end
        end
        uart_pkg::RX_DATA: begin
          if (rx_samp) begin
            rx_shift_q <= {rx_line, rx_shift_q[8:1]};
            rx_cnt_q   <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == (ctrl_q.mode9 ? 4'h8 : 4'h7)) begin
              rx_st_q <= uart_pkg::RX_STOP;
            end
          end
        end
        uart_pkg::RX_STOP: begin
          if (rx_samp) begin
            rx_st_q <= uart_pkg::RX_IDLE;
          end
        end
        default: rx_st_q <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buf_q <= uart_pkg::BYTE_RESET;
    end else if (rx_load) begin
      rx_buf_q <= ctrl_q.mode9 ? rx_shift_q[7:0] : rx_shift_q[8:1];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence tx_frame_begin_s;
    tx_bit_tick && !wr_data && (tx_cnt_q == (ctrl_q.mode9 ? uart_pkg::FRAME9_BITS : uart_pkg::FRAME8_BITS));
  endsequence

  sequence rx_stop_sample_s;
    rx_samp && (rx_st_q == uart_pkg::RX_STOP);
  endsequence

  data_read_rx_a: assert property (ar_fire && (rsel == uart_pkg::SEL_DATA) |=> rdata_q[7:0] == $past(rx_buf_q))
    else $error("data read did not return receive buffer");
  data_write_tx_a: assert property (wr_data |=> tx_cnt_q != 4'h0 && tx_shift_q[0] == 1'b0)
    else $error("data write did not start a frame");
  irq_follows_flag_a: assert property (int_en_q && ctrl_q.rx_done_flag |=> irq_q)
    else $error("interrupt not raised for set flag");
  flag_sw_clear_a: assert property ($fell(ctrl_q.tx_done_flag) || $fell(ctrl_q.rx_done_flag) |-> $past(wr_ctrl))
    else $error("flag cleared without software write");
  rx_reload_a: assert property (start_det |=> rx_count == $past(reload_q) && !rx_div_q)
    else $error("start did not reload receive counter");
  rx_hold_stop_a: assert property (!tmr_run_q && !start_det |=> $stable(rx_count))
    else $error("receive counter moved while timer stopped");
  tx_pin_tick_a: assert property (!$stable(tx_pin_q) |-> $past(tx_ovf && tx_div_q))
    else $error("tx line changed off the divided tick");
  tx_start_bit_a: assert property (tx_frame_begin_s |=> !tx_pin_q)
    else $error("frame did not begin with start bit");
  tx_done_stop_a: assert property ($rose(ctrl_q.tx_done_flag) |-> tx_pin_q && $past(tx_cnt_q == 4'h1))
    else $error("tx flag not at stop bit start");
  rx_load_cond_a: assert property (rx_stop_sample_s ##0 ctrl_q.rx_done_flag |=> $stable(rx_buf_q))
    else $error("receive buffer overwritten while flag set");

endmodule : uart_buffer_baud_gen

/* rtl/uart_pkg.sv */
// Function
// - full-duplex asynchronous port with variable-rate 8-bit and 9-bit frame modes
// - received byte is buffered so the next frame can already arrive
// - writing the data location loads transmit shifter and starts sending; never read back
// - reading the data location always returns the receive buffer
// - interrupt requested while enabled and either completion flag is set
// - completion flags stay set until software clears them
// - bit rate comes from an 8-bit auto-reload timer
// - transmit clock from visible counter, receive clock from hidden counter copy
// - both overflow streams are divided by two
// - receive copy counts only while timer runs, reloads from same byte
// - a start condition forces a reload of the receive counter copy
// - timer clock: system clock /4, /12, /48, oscillator /8, or timer pin
// - overflow rate is input clock over 256 minus reload; bit rate half that
// - 8-bit frame: start, eight data bits lsb first, stop
// - 9-bit frame: start, eight data bits, programmable ninth bit, stop
// - transmit flag rises at the start of the stop bit
// - receive loads and flags only if flag clear and checked bit high
package uart_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DATA      = 8'h04;
  localparam logic [7:0] OFS_TIMER     = 8'h08;
  localparam logic [7:0] OFS_COUNT     = 8'h0c;
  localparam logic [7:0] OFS_RELOAD    = 8'h10;

  localparam logic [7:0] CTRL_RESET    = 8'h40;
  localparam logic [7:0] TIMER_RESET   = 8'h00;
  localparam logic [7:0] BYTE_RESET    = 8'h00;

  // timer register fields
  localparam int         TMR_RUN_BIT   = 0;
  localparam int         TMR_SEL_LSB   = 1;
  localparam int         TMR_IE_BIT    = 7;

  // timer clock selections
  localparam logic [2:0] SEL_DIV12     = 3'h0;
  localparam logic [2:0] SEL_DIV4      = 3'h1;
  localparam logic [2:0] SEL_DIV48     = 3'h2;
  localparam logic [2:0] SEL_OSC8      = 3'h3;
  localparam logic [2:0] SEL_PIN       = 3'h4;

  localparam logic [5:0] PRE_WRAP      = 6'h2f;
  localparam logic [2:0] OSC_WRAP      = 3'h7;

  // frame lengths in bit times
  localparam logic [3:0] FRAME8_BITS   = 4'ha;
  localparam logic [3:0] FRAME9_BITS   = 4'hb;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [5:0] {
    SEL_CTRL   = 6'b000001,
    SEL_DATA   = 6'b000010,
    SEL_TIMER  = 6'b000100,
    SEL_COUNT  = 6'b001000,
    SEL_RELOAD = 6'b010000,
    SEL_NONE   = 6'b100000
  } reg_sel_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

  // serial_control_reg layout, bit 7 down to bit 0
  typedef struct packed {
    logic mode9;
    logic fixed_one;
    logic check_en;
    logic rx_en;
    logic tx_bit9;
    logic rx_bit9;
    logic tx_done_flag;
    logic rx_done_flag;
  } ctrl_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

endpackage : uart_pkg

/* sim/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_CYC = 16
) (
  input  wire logic sys_clk,
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [7:0] got_q;

  // ----------------------------------------
  // sender: idle line held high between frames
  // ----------------------------------------
  initial rx_line = 1'b1;

  task automatic send(input logic [7:0] b, input logic mode9, input logic bit9);
    rx_line <= 1'b0;
    repeat (BIT_CYC) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      rx_line <= b[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    if (mode9) begin
      rx_line <= bit9;
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask : send

  // ----------------------------------------
  // listener: samples mid-bit, lsb first
  // ----------------------------------------
  always begin
    @(negedge tx_line);
    repeat (BIT_CYC * 3 / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      got_q[i] = tx_line;
      repeat (BIT_CYC) @(posedge sys_clk);
    end
  end
endmodule : serial_peer

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0]  r;
  } row_t;
  logic               sys_clk;
  logic               nrst;
  uart_pkg::axi_req_t req;
  uart_pkg::axi_rsp_t rsp;
  logic               rx_line;
  logic               tx_line;
  logic               irq;
  logic               ext_osc;
  logic               timer_pin;
  logic [31:0]        rd;
  logic [1:0]         rs;
  int                 errors;
  int                 comparisons;
  row_t               rows [11];

  uart_buffer_baud_gen uart_buffer_baud_gen_i (
    .sys_clk         (sys_clk),
    .nrst            (nrst),
    .axi_req         (req),
    .axi_rsp         (rsp),
    .rx_pin          (rx_line),
    .ext_osc         (ext_osc),
    .timer_ext_input (timer_pin),
    .tx_pin_q        (tx_line),
    .irq_q           (irq)
  );

  serial_peer serial_peer_i (
    .sys_clk (sys_clk),
    .tx_line (tx_line),
    .rx_line (rx_line)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one access; each channel released at its own handshake
  // no cycle limit here: only the watchdog ends a wait for the answer
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    if (wr) begin
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
    end else begin
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
    end
    do begin
      @(posedge sys_clk);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
    end while (!(wr ? rsp.bvalid : rsp.rvalid));
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    rd = rsp.rdata;
    rs = wr ? rsp.bresp : rsp.rresp;
  endtask : axi

  task automatic wait_flag(input int b);
    int n = 0;
    do begin
      axi(1'b0, 8'h00, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    chk({31'h0, rd[b]}, 32'h1);
  endtask : wait_flag

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    req = '0;
    nrst = 1'b0;
    ext_osc = 1'b0;
    timer_pin = 1'b0;
    errors = 0;
    comparisons = 0;
    // timer: run, system clock /4, reload 0xfe gives a 16-cycle bit
    rows = '{'{1'b0, 8'h00, 32'h0, 32'h40, 2'h0}, '{1'b0, 8'h08, 32'h0, 32'h0, 2'h0},
             '{1'b1, 8'h10, 32'hfe, 32'h0, 2'h0}, '{1'b0, 8'h10, 32'h0, 32'hfe, 2'h0},
             '{1'b1, 8'h0c, 32'hfe, 32'h0, 2'h0}, '{1'b0, 8'h0c, 32'h0, 32'hfe, 2'h0},
             '{1'b1, 8'h08, 32'h83, 32'h0, 2'h0}, '{1'b0, 8'h08, 32'h0, 32'h83, 2'h0},
             '{1'b0, 8'h14, 32'h0, 32'h0, uart_pkg::RESP_SLVERR}, '{1'b1, 8'h00, 32'h10, 32'h0, 2'h0},
             '{1'b0, 8'h00, 32'h0, 32'h50, 2'h0}};
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      axi(rows[i].wr, rows[i].a, rows[i].d);
      chk({30'h0, rs}, {30'h0, rows[i].r});
      if (!rows[i].wr) chk(rd, rows[i].e);
    end
    axi(1'b1, 8'h04, 32'ha5);
    wait_flag(1);
    chk({24'h0, serial_peer_i.got_q}, 32'ha5);
    chk({31'h0, irq}, 32'h1);
    axi(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    axi(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h52);
    axi(1'b1, 8'h00, 32'h10);
    axi(1'b0, 8'h00, 32'h0);
    chk({31'h0, irq}, 32'h0);
    serial_peer_i.send(8'h3c, 1'b0, 1'b0);
    wait_flag(0);
    chk(rd, 32'h55);
    serial_peer_i.send(8'hc3, 1'b0, 1'b0);
    axi(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h3c);
    axi(1'b1, 8'h00, 32'hb0);
    serial_peer_i.send(8'h5a, 1'b1, 1'b0);
    axi(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hf0);
    serial_peer_i.send(8'h69, 1'b1, 1'b1);
    wait_flag(0);
    chk(rd, 32'hf5);
    axi(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h69);
    // timer pin and oscillator sources, counted on the visible counter
    axi(1'b1, 8'h08, 32'h08);
    axi(1'b1, 8'h0c, 32'h10);
    axi(1'b1, 8'h08, 32'h09);
    repeat (6) @(posedge sys_clk) timer_pin <= ~timer_pin;
    axi(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h13);
    axi(1'b1, 8'h08, 32'h07);
    repeat (32) @(posedge sys_clk) ext_osc <= ~ext_osc;
    axi(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h15);
    // reset in mid-run brings back the reset state
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    axi(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h40);
    axi(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end

  initial begin
    #200us;
    errors++;
    finish_test();
  end
endmodule : tb_top
